// ===== core/brl_core.sv
// Remote/local, clear, trigger and serial poll handling of bus commands.
// Assumes the bus interface hands over each command byte as a one-cycle
// strobe on aclk; REN and IFC arrive as raw line levels.
//
// Contract
// - Remote is entered only when REN is true and the device is then listen addressed.
// - IFC puts the device in local and idles the talker and listener.
// - IFC puts out the talk and listen lamps.
// - Once locked out, the front panel is ignored except for power.
// - Lockout is accepted only while REN is true.
// - Lockout ends only when REN goes false, never on go-to-local.
// - Go-to-local while listen addressed drops remote, lockout stays.
// - Device clear is obeyed unaddressed and restores power-up settings.
// - The defaults are volts, autorange, zero check on, no correction, no suppression, continuous external trigger.
// - The defaults are also prefix format, no storage, no service mask, no EOI or hold-off, CR LF terminator.
// - Group trigger starts a reading only in the two trigger-on-GET modes.
// - The primary address defaults to 27.
// - A serial poll returns the status byte at any time.
`timescale 1ns/1ns
`default_nettype none
module brl_core
  import brl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ren_line,
  input wire logic ifc_line,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic remote_q,
  output logic lockout_q,
  output logic listen_lamp_q,
  output logic talk_lamp_q,
  output logic panel_enable_q,
  output logic reading_trigger_q,
  output logic device_clear_q,
  output logic [31:0] settings_q,
  output logic poll_drive_q,
  output logic [7:0] poll_byte_q
);
  // Line synchronisers, three stages, change taken when 2 and 3 agree
  logic [2:0] ren_sync_q;
  logic [2:0] ifc_sync_q;
  logic ren_q;
  logic ifc_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ren_sync_q <= 3'h0;
      ifc_sync_q <= 3'h0;
      ren_q <= 1'b0;
      ifc_q <= 1'b0;
    end
    else
    begin
      ren_sync_q <= {ren_sync_q[1:0], ren_line};
      ifc_sync_q <= {ifc_sync_q[1:0], ifc_line};
      if (ren_sync_q[1] == ren_sync_q[2])
        ren_q <= ren_sync_q[2];
      if (ifc_sync_q[1] == ifc_sync_q[2])
        ifc_q <= ifc_sync_q[2];
    end
  end

  // Software registers and bus addressing state
  logic [4:0] addr_q;
  logic [7:0] status_byte_q;
  logic spoll_q;
  logic listen_q;
  logic talk_q;

  // Command decode; only listen and talk addresses are checked against the programmed address
  wire cmd_is_lag = cmd_valid && cmd_byte[7:5] == BRL_LAG_TAG;
  wire cmd_is_tag = cmd_valid && cmd_byte[7:5] == BRL_TAG_TAG;
  wire cmd_mine = cmd_byte[4:0] == addr_q;
  wire my_listen = cmd_is_lag && cmd_mine && cmd_byte != BRL_CMD_UNL;
  wire my_talk = cmd_is_tag && cmd_mine && cmd_byte != BRL_CMD_UNT;
  wire unlisten = cmd_valid && cmd_byte == BRL_CMD_UNL;
  // Another talker unaddresses us as talker
  wire untalk = cmd_is_tag && !my_talk;
  wire got_gtl = cmd_valid && cmd_byte == BRL_CMD_GTL;
  wire got_llo = cmd_valid && cmd_byte == BRL_CMD_LLO;
  wire got_dcl = cmd_valid && cmd_byte == BRL_CMD_DCL;
  wire got_sdc = cmd_valid && cmd_byte == BRL_CMD_SDC;
  wire got_get = cmd_valid && cmd_byte == BRL_CMD_GET;
  wire got_spe = cmd_valid && cmd_byte == BRL_CMD_SPE;
  wire got_spd = cmd_valid && cmd_byte == BRL_CMD_SPD;
  wire [2:0] trig_mode = settings_q[BRL_TRIG_LSB +: 3];
  wire get_mode = trig_mode == trigger_on_get_one_shot ||
    trig_mode == trigger_on_get_continuous;
  wire clear_now = got_dcl || (got_sdc && listen_q);

  // Addressing state; IFC wins over any byte in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end
    else if (ifc_q)
    begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end
    else
    begin
      if (my_listen)
        listen_q <= 1'b1;
      else if (unlisten)
        listen_q <= 1'b0;
      if (my_talk)
        talk_q <= 1'b1;
      else if (untalk || cmd_valid && cmd_byte == BRL_CMD_UNT)
        talk_q <= 1'b0;
    end
  end

  // Remote and lockout; REN false dominates everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end
    else if (!ren_q)
    begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end
    else
    begin
      if (ifc_q)
        remote_q <= 1'b0;
      else if (my_listen)
        remote_q <= 1'b1;
      else if (got_gtl && listen_q)
        remote_q <= 1'b0;
      // GTL leaves lockout alone on purpose
      if (got_llo)
        lockout_q <= 1'b1;
    end
  end

  // Lamps, panel gate, strobes and poll byte, all registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      listen_lamp_q <= 1'b0;
      talk_lamp_q <= 1'b0;
      panel_enable_q <= 1'b1;
      reading_trigger_q <= 1'b0;
      device_clear_q <= 1'b0;
      spoll_q <= 1'b0;
      poll_drive_q <= 1'b0;
      poll_byte_q <= 8'h00;
    end
    else
    begin
      listen_lamp_q <= listen_q && !ifc_q;
      talk_lamp_q <= talk_q && !ifc_q;
      // Panel dead in remote or lockout, power is not ours to gate
      panel_enable_q <= !remote_q && !lockout_q;
      reading_trigger_q <= got_get && listen_q && get_mode;
      device_clear_q <= clear_now;
      if (ifc_q || got_spd)
        spoll_q <= 1'b0;
      else if (got_spe)
        spoll_q <= 1'b1;
      poll_drive_q <= spoll_q && talk_q && !ifc_q;
      poll_byte_q <= status_byte_q;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ctrl = do_write && aw_addr_q == BRL_CTRL_OFS;
  wire wr_set = do_write && aw_addr_q == BRL_SET_OFS;
  wire wr_poll = do_write && aw_addr_q == BRL_POLL_OFS;
  wire wr_stat = do_write && aw_addr_q == BRL_STAT_OFS;
  wire wr_hit = wr_ctrl || wr_set || wr_poll || wr_stat;

  // Byte-lane merge of the held write data
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  wire [31:0] ctrl_word = {27'h0, addr_q};
  wire [31:0] ctrl_new = merge(ctrl_word, w_data_q, w_strb_q);
  wire [31:0] set_new = merge(settings_q, w_data_q, w_strb_q);
  wire [31:0] poll_new = merge({24'h0, status_byte_q}, w_data_q, w_strb_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BRL_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (w_take)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_q <= 1'b0;
      // Ready only while the slot is empty, so nothing is overwritten
      s_axi_awready <= !aw_have_q && !aw_take && !s_axi_awready;
      s_axi_wready <= !w_have_q && !w_take && !s_axi_wready;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? BRL_RESP_OKAY : BRL_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Registers; a bus clear beats a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_q <= BRL_ADDR_RESET;
      settings_q <= BRL_SET_RESET;
      status_byte_q <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        addr_q <= ctrl_new[BRL_ADDR_LSB +: BRL_ADDR_W];
      if (clear_now)
        settings_q <= BRL_SET_RESET;
      else if (wr_set)
        settings_q <= set_new;
      if (wr_poll)
        status_byte_q <= poll_new[7:0];
    end
  end

  // Read path
  wire [31:0] stat_word = {24'h0, ifc_q, ren_q, spoll_q, panel_enable_q,
    talk_q, listen_q, lockout_q, remote_q};
  wire rd_ctrl = s_axi_araddr == BRL_CTRL_OFS;
  wire rd_set = s_axi_araddr == BRL_SET_OFS;
  wire rd_stat = s_axi_araddr == BRL_STAT_OFS;
  wire rd_poll = s_axi_araddr == BRL_POLL_OFS;
  wire rd_hit = rd_ctrl || rd_set || rd_stat || rd_poll;
  wire [31:0] rd_word = rd_ctrl ? ctrl_word :
    rd_set ? settings_q :
    rd_stat ? stat_word :
    rd_poll ? {24'h0, status_byte_q} : 32'h0;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= BRL_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? BRL_RESP_OKAY : BRL_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/brl_pkg.sv
// Package for the remote/local bus command interpreter.
// Assumes a 32-bit AXI4-Lite register bus and decoded bus bytes.
package brl_pkg;
  // Register byte offsets
  localparam logic [7:0] BRL_CTRL_OFS = 8'h00;
  localparam logic [7:0] BRL_SET_OFS = 8'h04;
  localparam logic [7:0] BRL_STAT_OFS = 8'h08;
  localparam logic [7:0] BRL_POLL_OFS = 8'h0c;
  // Control register fields
  localparam int BRL_ADDR_LSB = 0;
  localparam int BRL_ADDR_W = 5;
  localparam logic [4:0] BRL_ADDR_RESET = 5'h1b;
  // Settings register fields
  localparam int BRL_FUNC_LSB = 0;
  localparam int BRL_RANGE_LSB = 3;
  localparam int BRL_ZCHK_BIT = 7;
  localparam int BRL_ZCOR_BIT = 8;
  localparam int BRL_SUPP_BIT = 9;
  localparam int BRL_TRIG_LSB = 10;
  localparam int BRL_FMT_LSB = 13;
  localparam int BRL_STORE_LSB = 15;
  localparam int BRL_MASK_LSB = 18;
  localparam int BRL_EOI_BIT = 26;
  localparam int BRL_HOLD_BIT = 27;
  localparam int BRL_TERM_LSB = 28;
  // Option codes
  localparam logic [2:0] function_volts_option = 3'h0;
  localparam logic [3:0] range_auto_option = 4'h0;
  localparam logic zero_check_on_option = 1'b1;
  localparam logic zero_correct_off_option = 1'b0;
  localparam logic suppression_off_option = 1'b0;
  localparam logic [2:0] trigger_continuous_external_option = 3'h6;
  localparam logic [2:0] trigger_on_get_one_shot = 3'h2;
  localparam logic [2:0] trigger_on_get_continuous = 3'h3;
  localparam logic [1:0] format_prefix_option = 2'h0;
  localparam logic [2:0] storage_off_option = 3'h7;
  localparam logic [7:0] service_mask_off_option = 8'h00;
  localparam logic eoi_holdoff_off_option = 1'b0;
  localparam logic [1:0] term_cr_lf_option = 2'h0;
  // Power-up settings word
  localparam logic [31:0] BRL_SET_RESET = {2'h0, term_cr_lf_option,
    eoi_holdoff_off_option, eoi_holdoff_off_option,
    service_mask_off_option, storage_off_option, format_prefix_option,
    trigger_continuous_external_option, suppression_off_option,
    zero_correct_off_option, zero_check_on_option, range_auto_option,
    function_volts_option};
  // Bus command bytes
  localparam logic [7:0] BRL_CMD_GTL = 8'h01;
  localparam logic [7:0] BRL_CMD_SDC = 8'h04;
  localparam logic [7:0] BRL_CMD_GET = 8'h08;
  localparam logic [7:0] BRL_CMD_LLO = 8'h11;
  localparam logic [7:0] BRL_CMD_DCL = 8'h14;
  localparam logic [7:0] BRL_CMD_SPE = 8'h18;
  localparam logic [7:0] BRL_CMD_SPD = 8'h19;
  localparam logic [7:0] BRL_CMD_UNL = 8'h3f;
  localparam logic [7:0] BRL_CMD_UNT = 8'h5f;
  localparam logic [2:0] BRL_LAG_TAG = 3'h1;
  localparam logic [2:0] BRL_TAG_TAG = 3'h2;
  // Responses
  localparam logic [1:0] BRL_RESP_OKAY = 2'h0;
  localparam logic [1:0] BRL_RESP_SLVERR = 2'h2;
endpackage

// ===== sim/brl_ctl_model.sv
// Behavioural system controller: REN, IFC and command bytes.
// Assumes the bench calls its tasks; outputs change after aclk rises.
`timescale 1ns/1ns
`default_nettype none
module brl_ctl_model (
  input wire logic aclk,
  output logic ren_line,
  output logic ifc_line,
  output logic cmd_valid,
  output logic [7:0] cmd_byte
);
  // Idle lines at time zero
  initial
  begin
    ren_line = 1'b0;
    ifc_line = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
  end
  // Released byte shows its inverse so a stale copy cannot pass
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask
  // REN settles before any listen address or lockout follows
  task automatic set_ren(input logic v);
    @(posedge aclk);
    ren_line <= v;
    repeat (6) @(posedge aclk);
  endtask
  // Long enough to get through the line synchroniser
  task automatic pulse_ifc();
    @(posedge aclk);
    ifc_line <= 1'b1;
    repeat (8) @(posedge aclk);
    ifc_line <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ===== sim/brl_monitor.sv
// Checker for the bus command side of brl_core.
// Assumes one aclk domain; aresetn low is a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module brl_monitor
  import brl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ren_line,
  input wire logic ifc_line,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic remote_q,
  input wire logic lockout_q,
  input wire logic listen_lamp_q,
  input wire logic talk_lamp_q,
  input wire logic panel_enable_q,
  input wire logic reading_trigger_q,
  input wire logic device_clear_q,
  input wire logic [31:0] settings_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Decoded strobes and the two trigger-on-GET modes
  wire get_cmd = cmd_valid && cmd_byte == BRL_CMD_GET;
  wire get_mode = settings_q[12:10] == trigger_on_get_one_shot ||
    settings_q[12:10] == trigger_on_get_continuous;
  // DCL strobe, and line levels held long enough to pass the synchroniser
  sequence s_dcl;
    cmd_valid && cmd_byte == BRL_CMD_DCL;
  endsequence
  sequence s_ifc_held;
    ifc_line [*7];
  endsequence
  sequence s_ren_low;
    !ren_line [*7];
  endsequence
  AST_DCL_PULSE: assert property (s_dcl |-> ##[1:2] device_clear_q)
    else $error("no clear pulse after DCL");
  AST_CLR_DEFAULTS: assert property (
    device_clear_q |-> ##[0:1] settings_q == BRL_SET_RESET)
    else $error("clear left settings changed");
  AST_LLO_SOURCE: assert property (
    $rose(lockout_q) |-> $past(cmd_valid && cmd_byte == BRL_CMD_LLO))
    else $error("lockout without LLO");
  AST_GTL_KEEPS_LOCK: assert property (
    $fell(lockout_q) |-> !$past(cmd_valid && cmd_byte == BRL_CMD_GTL))
    else $error("GTL cleared lockout");
  AST_PANEL_LOCKED: assert property (
    $past(lockout_q) && lockout_q |-> !panel_enable_q)
    else $error("panel usable under lockout");
  AST_REMOTE_SOURCE: assert property (
    $rose(remote_q) |-> $past(cmd_valid && cmd_byte[7:5] == BRL_LAG_TAG))
    else $error("remote without listen address");
  AST_GET_TRIGGER: assert property (
    $rose(reading_trigger_q) |-> $past(get_cmd && get_mode))
    else $error("trigger without GET in GET mode");
  AST_IFC_IDLE: assert property (
    s_ifc_held |-> !remote_q && !listen_lamp_q && !talk_lamp_q)
    else $error("IFC left remote or lamps on");
  AST_REN_RELEASE: assert property (
    s_ren_low |-> !remote_q && !lockout_q)
    else $error("REN false left remote or lockout");
endmodule
bind brl_core brl_monitor u_mon (.aclk, .aresetn, .ren_line, .ifc_line,
  .cmd_valid, .cmd_byte, .remote_q, .lockout_q, .listen_lamp_q,
  .talk_lamp_q, .panel_enable_q, .reading_trigger_q, .device_clear_q,
  .settings_q);
`default_nettype wire

// ===== sim/bus_remote_local_control_tb.sv
// Self-checking bench for brl_core with a controller model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
`default_nettype none
module bus_remote_local_control_tb;
  import brl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, settings_q, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ren_line, ifc_line, cmd_valid, remote_q, lockout_q;
  logic listen_lamp_q, talk_lamp_q, panel_enable_q, reading_trigger_q;
  logic device_clear_q, poll_drive_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] cmd_byte, poll_byte_q;
  int n_mismatch = 0, checks = 0, n_trig = 0, n_clr = 0, t0;
  // Rows: command byte, expected remote, expected lockout
  logic [9:0] rows [6] = '{{8'h3b, 2'b10}, {8'h01, 2'b00},
    {8'h11, 2'b01}, {8'h3b, 2'b11}, {8'h01, 2'b01}, {8'h3b, 2'b11}};
  always #10 aclk = ~aclk;
  brl_ctl_model ctl (.aclk, .ren_line, .ifc_line, .cmd_valid, .cmd_byte);
  brl_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ren_line, .ifc_line,
    .cmd_valid, .cmd_byte, .remote_q, .lockout_q, .listen_lamp_q,
    .talk_lamp_q, .panel_enable_q, .reading_trigger_q, .device_clear_q,
    .settings_q, .poll_drive_q, .poll_byte_q);
  // Pulse counters, so a doubled pulse shows up too
  always @(posedge aclk)
  begin
    n_trig <= n_trig + int'(reading_trigger_q === 1'b1);
    n_clr <= n_clr + int'(device_clear_q === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready)
    begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        rr = s_axi_bresp;
      end
      @(posedge aclk);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arvalid || s_axi_rready)
    begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
      end
      @(posedge aclk);
    end
  endtask
  // Lamps and panel follow two edges after the byte
  task automatic cmd(input logic [7:0] b);
    ctl.send(b);
    repeat (3) @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog: the tests need about 300 cycles
  initial
  begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("settings", BRL_SET_RESET, settings_q);
    chk("panel", 1'b1, panel_enable_q);
    rd_reg(BRL_CTRL_OFS);
    chk("address", 32'h1b, rd & 32'h1f);
    rd_reg(8'h10);
    chk("unmapped", BRL_RESP_SLVERR, rr);
    // Unmapped write is refused with an error response
    wr(8'h10, 32'h0);
    chk("write resp", BRL_RESP_SLVERR, rr);
    $display("test reset done");
    // Listen address and lockout while REN is false
    cmd(8'h3b);
    cmd(BRL_CMD_LLO);
    chk("remote", 1'b0, remote_q);
    chk("lockout", 1'b0, lockout_q);
    cmd(BRL_CMD_UNL);
    ctl.set_ren(1'b1);
    chk("remote", 1'b0, remote_q);
    for (int i = 0; i < 6; i++)
    begin
      cmd(rows[i][9:2]);
      chk("remote", rows[i][1], remote_q);
      chk("lockout", rows[i][0], lockout_q);
    end
    chk("panel", 1'b0, panel_enable_q);
    ctl.set_ren(1'b0);
    chk("remote", 1'b0, remote_q);
    chk("lockout", 1'b0, lockout_q);
    $display("test remote done");
    // Every trigger mode, still listen addressed
    for (int m = 0; m < 8; m++)
    begin
      wr(BRL_SET_OFS, 32'(m) << 10);
      t0 = n_trig;
      cmd(BRL_CMD_GET);
      chk("trigger", 32'(m == 2 || m == 3), 32'(n_trig - t0));
    end
    $display("test trigger done");
    // SDC ignored unaddressed, DCL obeyed unaddressed
    cmd(BRL_CMD_UNL);
    cmd(BRL_CMD_SDC);
    chk("settings", 32'h1c00, settings_q);
    t0 = n_clr;
    cmd(BRL_CMD_DCL);
    chk("settings", BRL_SET_RESET, settings_q);
    chk("clear", 32'h1, 32'(n_clr - t0));
    wr(BRL_SET_OFS, 32'h1c00);
    cmd(8'h3b);
    cmd(BRL_CMD_SDC);
    chk("settings", BRL_SET_RESET, settings_q);
    $display("test clear done");
    // IFC idles talker and listener and puts the lamps out
    ctl.set_ren(1'b1);
    cmd(8'h3b);
    cmd(8'h5b);
    chk("talk lamp", 1'b1, talk_lamp_q);
    chk("listen lamp", 1'b1, listen_lamp_q);
    ctl.pulse_ifc();
    chk("remote", 1'b0, remote_q);
    chk("listen lamp", 1'b0, listen_lamp_q);
    chk("talk lamp", 1'b0, talk_lamp_q);
    $display("test ifc done");
    // Serial poll without any service request
    wr(BRL_POLL_OFS, 32'ha5);
    chk("write resp", BRL_RESP_OKAY, rr);
    cmd(BRL_CMD_SPE);
    cmd(8'h5b);
    chk("poll drive", 1'b1, poll_drive_q);
    chk("poll byte", 8'ha5, poll_byte_q);
    cmd(BRL_CMD_SPD);
    chk("poll drive", 1'b0, poll_drive_q);
    $display("test poll done");
    // Mid-run reset must bring back address and settings defaults
    wr(BRL_CTRL_OFS, 32'h05);
    wr(BRL_SET_OFS, 32'h0800);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("settings", BRL_SET_RESET, settings_q);
    chk("poll drive", 1'b0, poll_drive_q);
    rd_reg(BRL_CTRL_OFS);
    chk("address", 32'h1b, rd & 32'h1f);
    $display("test reset again done");
    report_and_stop();
  end
endmodule
`default_nettype wire
